// ### hw/palc_pkg.sv
// Package with register map, field positions and types for the aggressive power and LED control block.
// Summary of operation
// - slumber select 0: enter partial when idle
// - slumber select 1: enter slumber when idle
// - bit 26 enables autonomous low power entry
// - bit 25 gates activity LED with flag
// - bit 24 marks packet device, gates LED
// - bit 21 shows external connector accessibility
// - bit 21 set forces capability bit set
// - bit 18 shows joint hot plug connector
package palc_pkg;
    localparam logic [11:0] palc_off_cmd = 12'h000;
    localparam logic [11:0] palc_off_slots = 12'h004;
    localparam logic [11:0] palc_off_state = 12'h008;
    localparam logic [11:0] palc_off_cap = 12'h00c;
    localparam int palc_bit_slumber = 27;
    localparam int palc_bit_auto_low_power_enable = 26;
    localparam int palc_bit_packet_device_led_enable = 25;
    localparam int palc_bit_packet_device_flag = 24;
    localparam int palc_bit_esp = 21;
    localparam int palc_bit_hot_plug_capable = 18;
    localparam int palc_bit_sxs = 5;
    localparam int palc_bit_any_issue = 0;
    localparam int palc_bit_any_active = 1;
    localparam logic [31:0] palc_cmd_wmask = 32'h0f240000;
    localparam logic [31:0] palc_cmd_reset = 32'h00000000;
    localparam logic [31:0] palc_zero = 32'h00000000;
    localparam logic [1:0] palc_idle_state = 2'h0;

    typedef enum logic [1:0] {
        palc_active,
        palc_partial,
        palc_slumber
    } palc_pstate_t;

    typedef struct packed {
        logic [31:0] issue;
        logic [31:0] active;
    } palc_slots_t;
endpackage

// ### hw/palc_ctrl.sv
// Port command register slice with autonomous link power entry and activity LED.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/10ps
module palc_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire palc_pkg::palc_slots_t slots,
    input wire logic wake_req,
    output palc_pkg::palc_pstate_t link_state,
    output logic activity_led_out
);
    import palc_pkg::*;

    // Places one flag at the given bit of an otherwise clear read word.
    function automatic logic [31:0] flag_word(
        input logic flag,
        input int pos
    );
        logic [31:0] word;
        word = palc_zero;
        word[pos] = flag;
        return word;
    endfunction

    // Reduces one slot register to a single outstanding indication.
    function automatic logic any_slot(
        input logic [31:0] slot_bits
    );
        return |slot_bits;
    endfunction

    // Zero-extends the link state code into a read word.
    function automatic logic [31:0] state_to_word(
        input palc_pstate_t state
    );
        logic [31:0] word;
        word = palc_zero;
        word[$bits(palc_pstate_t)-1:0] = state;
        return word;
    endfunction

    // Register storage.
    logic [31:0] port_command_control;
    logic [31:0] next_command;
    palc_pstate_t next_link_state;
    logic busy_q;
    logic led_q;
    logic next_led;
    logic [31:0] next_rdata;

    // Bus decode.
    wire access = psel & penable;
    wire setup_rd = psel & ~penable & ~pwrite;
    wire hit_cmd = paddr == palc_off_cmd;
    wire hit_slots = paddr == palc_off_slots;
    wire hit_state = paddr == palc_off_state;
    wire hit_cap = paddr == palc_off_cap;
    wire mapped = hit_cmd | hit_slots | hit_state | hit_cap;
    wire wr_cmd = access & pwrite & hit_cmd;

    // Command register fields.
    wire auto_low_power_enable = port_command_control[palc_bit_auto_low_power_enable];
    wire slumber_over_partial_select = port_command_control[palc_bit_slumber];
    wire led_enable = port_command_control[palc_bit_packet_device_led_enable];
    wire packet_device_flag = port_command_control[palc_bit_packet_device_flag];
    wire external_signal_only_port = port_command_control[palc_bit_esp];

    // Outstanding command tracking.
    wire any_issue = any_slot(slots.issue);
    wire any_active = any_slot(slots.active);
    wire busy = any_issue | any_active;
    // The transition fires on the falling edge of the busy condition, which is the moment
    // the last outstanding slot is cleared while the other register is already empty.
    // A port that was never busy therefore never drops into a low power state on its own.
    wire went_idle = busy_q & ~busy;

    // Read words of the status offsets.
    wire [31:0] slots_word;
    wire [31:0] state_word;
    wire [31:0] cap_word;

    assign slots_word = flag_word(any_issue, palc_bit_any_issue) | flag_word(any_active, palc_bit_any_active);
    assign state_word = state_to_word(link_state);

    assign cap_word = flag_word(external_signal_only_port, palc_bit_sxs);

    // The slave never stretches a transfer, so every access completes in two cycles.
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign activity_led_out = led_q;

    // hot plug flag kept
    // Only the documented writable fields survive the mask; the hot plug and external
    // port flags are platform settings, and their exclusivity is left to software.
    assign next_command = pwdata & palc_cmd_wmask;

    assign next_led = led_enable & packet_device_flag & busy;

    always_comb begin
        next_link_state = link_state;
        unique case (link_state)
            palc_active: begin
                if (!wake_req && !busy && went_idle && auto_low_power_enable) begin
                    next_link_state = slumber_over_partial_select ? palc_slumber : palc_partial;
                end
            end
            palc_partial, palc_slumber: begin
                if (wake_req || busy) begin
                    next_link_state = palc_active;
                end
            end
            default: begin
                // The fourth code is unused; recover to active rather than lock up.
                next_link_state = palc_active;
            end
        endcase
    end

    // Read data selection, loaded in the setup cycle.
    always_comb begin
        next_rdata = palc_zero;
        if (hit_cmd) begin
            next_rdata = port_command_control;
        end else if (hit_slots) begin
            next_rdata = slots_word;
        end else if (hit_state) begin
            next_rdata = state_word;
        end else if (hit_cap) begin
            next_rdata = cap_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_command_control <= palc_cmd_reset;
        end else if (wr_cmd) begin
            port_command_control <= next_command;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_state <= palc_active;
        end else begin
            link_state <= next_link_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_q <= 1'b0;
        end else begin
            led_q <= next_led;
        end
    end

    // Read data register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= palc_zero;
        end else if (setup_rd) begin
            prdata <= next_rdata;
        end
    end

    // Notes for integration.
    // The slot inputs are expected on this clock; they come from the command engine
    // of the same port and are not synchronised here.
    // The wake request is a level from the same clock domain as well.
    // A wake request always wins over an autonomous entry in the same cycle, so a
    // transfer that is about to start never sees the link fall asleep under it.
    // The link state output is only the decision of this block; the link layer that
    // carries out the state change is outside it.
    // The low power state is left as soon as any slot is raised again, which trades
    // a little extra power for the shortest possible command latency.
    // An unmapped access raises the error response and leaves every register alone except the read data register, which an unmapped read clears.
    // Writes to the read-only offsets are ignored without an error response.
    // The read data register holds its value between reads, which keeps the bus quiet.
    // The activity LED follows the busy condition one cycle late while bits 25 and 24 are both set,
    // which is far below anything a person can see.
    // Reserved bits of the command register read back as zero after any write.
    // Clearing the enable bit does not pull the link out of a low power state; only
    // new work or a wake request does.
    // The slumber select bit is read at the moment of entry only.
    // Changing it while the link is asleep takes effect at the next entry.
    // The capability mirror follows the external port flag with no delay.
    // The slot status word shows the reduced levels, not the individual slots.
    // The link state word shows the current code in its lowest bits.
    // All registers return to zero on reset, so the link starts active.
    // No register has a side effect on read.
    // The block has no interrupt of its own.
endmodule // palc_ctrl

// ### verification/palc_dev_model.sv
// Device-side model that raises and retires command slots.
`timescale 1ns/10ps
module palc_dev_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] load,
    output palc_pkg::palc_slots_t slots
);
    import palc_pkg::*;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            slots <= '0;
        else
            slots <= {31'h0, load[0], 31'h0, load[1]};
endmodule // palc_dev_model

// ### verification/palc_ctrl_monitor.sv
// Checker of power entry, LED and register rules at the ports.
`timescale 1ns/10ps
module palc_ctrl_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire palc_pkg::palc_slots_t slots,
    input wire logic wake_req,
    input wire palc_pkg::palc_pstate_t link_state,
    input wire logic activity_led_out
);
    import palc_pkg::*;
    logic [31:0] cmd;
    wire rd = psel && penable && !pwrite;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            cmd <= '0;
        else if (psel && penable && pwrite && paddr == palc_off_cmd)
            cmd <= pwdata & palc_cmd_wmask;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_partial_entry: assert property ($fell(|slots) && !wake_req && cmd[palc_bit_auto_low_power_enable] && !cmd[palc_bit_slumber] |=> link_state == palc_partial)
        else $error("partial missed");
    a_slumber_entry: assert property ($fell(|slots) && !wake_req && cmd[palc_bit_auto_low_power_enable] && cmd[palc_bit_slumber] |=> link_state == palc_slumber)
        else $error("slumber missed");
    a_auto_off: assert property (!cmd[palc_bit_auto_low_power_enable] && link_state == palc_active |=> link_state == palc_active)
        else $error("entry while disabled");
    a_led_follow: assert property (activity_led_out == $past(cmd[palc_bit_packet_device_led_enable] && cmd[palc_bit_packet_device_flag] && |slots))
        else $error("led wrong");
    a_cmd_readback: assert property (rd && paddr == palc_off_cmd |-> prdata == cmd)
        else $error("cmd read wrong");
    a_cap_follow: assert property (rd && paddr == palc_off_cap |-> prdata[palc_bit_sxs] == cmd[palc_bit_esp])
        else $error("cap bit wrong");
    a_error_unmapped: assert property (psel && penable && paddr > palc_off_cap |-> pslverr)
        else $error("no error");
    a_ready_high: assert property (pready)
        else $error("not ready");
endmodule // palc_ctrl_monitor

// ### verification/palc_ctrl_bench.sv
// Bench for the power entry and LED control block.
`timescale 1ns/10ps
module palc_ctrl_bench;
    import palc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wake_req = 0, pready, pslverr, activity_led_out, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, w;
    logic [1:0] load = 0;
    logic [15:0] lf = 16'h3ef8;
    palc_slots_t slots;
    palc_pstate_t link_state;
    int err_count = 0, checks = 0;
    palc_ctrl palc_ctrl_inst (.*);
    palc_dev_model palc_dev_model_inst (.*);
    initial forever #5 pclk = ~pclk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %0t %h %h", $time, s, e);
        end
    endtask
    function automatic palc_pstate_t exp_state(input logic enable, input logic deep);
        if (!enable)
            return palc_active;
        return deep ? palc_slumber : palc_partial;
    endfunction
    task automatic complete_run;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (!pready && ++n < 9);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (n > 8) begin
            err_count++;
            complete_run;
        end
        @(posedge pclk);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        xfer(0, 12'h010, 0);
        chk(er, 1);
        for (int i = 0; i < 8; i++) begin
            lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
            w = {lf[15:12], i[1:0], lf[9:0], lf};
            w[18] = w[18] & !w[21];
            xfer(1, palc_off_cmd, w);
            xfer(0, palc_off_cmd, 0);
            chk(rd, w & palc_cmd_wmask);
            xfer(0, palc_off_cap, 0);
            chk(rd[palc_bit_sxs], w[palc_bit_esp]);
            load <= lf[1:0] | 2'h1;
            repeat (2) @(posedge pclk);
            load <= 0;
            #1 chk(activity_led_out, w[palc_bit_packet_device_led_enable] & w[palc_bit_packet_device_flag]);
            repeat (3) @(posedge pclk);
            #1 chk(link_state, exp_state(w[palc_bit_auto_low_power_enable], w[palc_bit_slumber]));
            @(posedge pclk);
            wake_req <= 1;
            @(posedge pclk);
            wake_req <= 0;
            #1 chk(link_state, palc_active);
            @(posedge pclk);
            $display("test %0d done", i);
        end
        complete_run;
    end
endmodule // palc_ctrl_bench
bind palc_ctrl palc_ctrl_monitor palc_ctrl_monitor_inst (.*);
